// ---- ocd_pkg.sv ----
// Purpose: Shared constants for the output channel divider and driver
// Assumes: Byte-wide registers, each in the low lane of one Wishbone word
// Notes: Register byte address is four times the register index
package ocd_pkg;
  localparam int OCD_ADR_W = 14;
  localparam int OCD_IDX_W = 12;
  localparam int OCD_DIV_W = 10;
  localparam int OCD_PH_W = 6;
  localparam int OCD_POS_W = 13;
  // Register indices
  localparam logic [11:0] OCD_IDX_SYNC_MASK = 12'h0436;
  localparam logic [11:0] OCD_IDX_DRIVE_CFG = 12'h0437;
  localparam logic [11:0] OCD_IDX_DIV_LOW = 12'h0438;
  localparam logic [11:0] OCD_IDX_DIV_HIGH = 12'h0439;
  localparam logic [11:0] OCD_IDX_DIV_PHASE = 12'h043a;
  // Field layout
  localparam int OCD_POL_BIT = 0;
  localparam int OCD_DRV_LSB = 1;
  localparam int OCD_DRV_MSB = 2;
  localparam int OCD_MASK_BIT = 0;
  localparam int OCD_DIVH_MSB = 1;
  localparam int OCD_PH_MSB = 5;
  // Drive codes
  localparam logic [1:0] OCD_DRV_LOW = 2'h0;
  localparam logic [1:0] OCD_DRV_MID = 2'h1;
  localparam logic [1:0] OCD_DRV_HIGH = 2'h2;
  localparam logic [1:0] OCD_DRV_OFF = 2'h3;
  // Reset values
  localparam logic [7:0] OCD_RST_BYTE = 8'h00;
  localparam logic [31:0] OCD_RD_ZERO = 32'h0000_0000;
  typedef enum logic [0:0] {OCD_HELD, OCD_RUN} ocd_state_t;
endpackage

// ---- ocd_divider.sv ----
// Purpose: Integer divider with half-period start phase, two samples per clock
// Assumes: REF_CLK is the divider input clock from the upstream prescaler
// Notes: Position counts half periods; bit 1 of level is the first half of a cycle
module ocd_divider
  import ocd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [OCD_DIV_W-1:0] div,
  input wire logic [OCD_PH_W-1:0] phase,
  input wire logic sync,
  input wire logic mask,
  output logic [1:0] level
);
  ocd_state_t state;
  logic signed [OCD_POS_W-1:0] pos;
  logic signed [OCD_POS_W-1:0] next_pos;
  logic signed [OCD_POS_W-1:0] per2;
  logic signed [OCD_POS_W-1:0] pos_b;
  logic [OCD_POS_W-1:0] per;

  // High for the first half of the period, low before the phase delay ends
  function automatic logic lvl(input logic signed [OCD_POS_W-1:0] p,
                               input logic [OCD_POS_W-1:0] hi_len);
    lvl = (p >= 0) && ($unsigned(p) < hi_len);
  endfunction

  assign per = {{(OCD_POS_W-OCD_DIV_W){1'b0}}, div} + 13'h0001;
  assign per2 = $signed(per << 1);

  // Advance two half periods each clock, wrap at one output period
  always_comb begin
    next_pos = pos + 13'sh0002;
    if (next_pos >= per2) begin
      next_pos = next_pos - per2;
    end
    if (next_pos >= per2) begin
      next_pos = '0; // Divide value shrank mid-period
    end
  end

  // Sync restarts at minus phase so the first edge lags by phase half periods
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= OCD_HELD;
      pos <= '0;
    end else if (sync && !mask) begin
      state <= OCD_RUN;
      pos <= -$signed({{(OCD_POS_W-OCD_PH_W){1'b0}}, phase});
    end else if (state == OCD_RUN || mask) begin
      state <= OCD_RUN;
      pos <= next_pos;
    end
  end

  // Second half sample wraps into the next period when the phase is odd
  always_comb begin
    pos_b = pos + 13'sh0001;
    if (pos_b >= per2) begin
      pos_b = pos_b - per2;
    end
  end

  // Levels at this half and the next, held low while waiting for sync
  always_comb begin
    case (state)
      OCD_RUN: level = {lvl(pos, per), lvl(pos_b, per)};
      default: level = 2'b00;
    endcase
  end
endmodule

// ---- ocd_channel.sv ----
// Functional notes
// - Drive bits [2:1]: 00 lowest (reset), 01 intermediate, 10 highest drive.
// - Drive code 11 powers the driver down, both pins high impedance.
// - Config bit 0 inverts output polarity; reset value 0 passes unchanged.
// - Channel divides its input clock by programmed 10-bit value plus one.
// - Divide value is low byte plus bits [1:0] of the high register.
// - Phase bits [5:0] delay start after sync in half input periods.
// - Divide, phase and output configuration all reset to zero.
// - Sync mask set frees the divider and makes it ignore sync events.
//
// Purpose: One clock output channel: registers, divider, polarity, driver control
// Assumes: Classic Wishbone slave, one ack per request, REF_CLK at 100 MHz
// Notes: Each output pair carries two half-cycle samples per REF_CLK cycle
module ocd_channel
  import ocd_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [OCD_ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SYNC,
  output logic [1:0] OUT_A_P,
  output logic [1:0] OUT_A_N,
  output logic OUT_A_OE_N,
  output logic [1:0] OUT_A_DRIVE
);
  logic [7:0] output_drive_config;
  logic [7:0] channel_divide_low;
  logic [7:0] channel_divide_high;
  logic [7:0] channel_divide_phase;
  logic sync_mask;
  logic [OCD_IDX_W-1:0] idx;
  logic req;
  logic wr_en;
  logic [1:0] div_level;
  logic [1:0] pol_level;
  logic [31:0] next_rd;
  logic [OCD_DIV_W-1:0] div_value;

  assign idx = WB_ADR_I[OCD_IDX_W+1:2];
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // Writes land once, on the cycle the ack is raised, low lane only
  assign wr_en = req && WB_WE_I && WB_SEL_I[0];
  assign div_value = {channel_divide_high[OCD_DIVH_MSB:0], channel_divide_low};

  // Register writes; reserved bits never store so they read back zero
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      output_drive_config <= OCD_RST_BYTE;
      channel_divide_low <= OCD_RST_BYTE;
      channel_divide_high <= OCD_RST_BYTE;
      channel_divide_phase <= OCD_RST_BYTE;
      sync_mask <= 1'b0;
    end else if (wr_en) begin
      case (idx)
        OCD_IDX_DRIVE_CFG: output_drive_config <= {5'h00, WB_DAT_I[OCD_DRV_MSB:0]};
        OCD_IDX_DIV_LOW: channel_divide_low <= WB_DAT_I[7:0];
        OCD_IDX_DIV_HIGH: channel_divide_high <= {6'h00, WB_DAT_I[OCD_DIVH_MSB:0]};
        OCD_IDX_DIV_PHASE: channel_divide_phase <= {2'h0, WB_DAT_I[OCD_PH_MSB:0]};
        OCD_IDX_SYNC_MASK: sync_mask <= WB_DAT_I[OCD_MASK_BIT];
        default: sync_mask <= sync_mask; // Unmapped writes are dropped
      endcase
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    next_rd = OCD_RD_ZERO;
    case (idx)
      OCD_IDX_DRIVE_CFG: next_rd[7:0] = output_drive_config;
      OCD_IDX_DIV_LOW: next_rd[7:0] = channel_divide_low;
      OCD_IDX_DIV_HIGH: next_rd[7:0] = channel_divide_high;
      OCD_IDX_DIV_PHASE: next_rd[7:0] = channel_divide_phase;
      OCD_IDX_SYNC_MASK: next_rd[OCD_MASK_BIT] = sync_mask;
      default: next_rd = OCD_RD_ZERO;
    endcase
  end

  // Ack one cycle after the request, drop it the cycle after
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= OCD_RD_ZERO;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= req ? next_rd : OCD_RD_ZERO;
    end
  end

  ocd_divider u_div (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .div(div_value),
    .phase(channel_divide_phase[OCD_PH_MSB:0]),
    .sync(SYNC),
    .mask(sync_mask),
    .level(div_level)
  );

  // Polarity sits after the phase offset, ahead of the power-down gate
  assign pol_level = output_drive_config[OCD_POL_BIT] ? ~div_level : div_level;

  // Driver outputs; powered down pair idles low and releases the pins
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      OUT_A_P <= 2'b00;
      OUT_A_N <= 2'b00;
      OUT_A_OE_N <= 1'b0;
      OUT_A_DRIVE <= OCD_DRV_LOW;
    end else if (output_drive_config[OCD_DRV_MSB:OCD_DRV_LSB] == OCD_DRV_OFF) begin
      OUT_A_P <= 2'b00;
      OUT_A_N <= 2'b00;
      OUT_A_OE_N <= 1'b1;
      OUT_A_DRIVE <= OCD_DRV_OFF;
    end else begin
      OUT_A_P <= pol_level;
      OUT_A_N <= ~pol_level;
      OUT_A_OE_N <= 1'b0;
      OUT_A_DRIVE <= output_drive_config[OCD_DRV_MSB:OCD_DRV_LSB];
    end
  end
endmodule

// ---- ocd_channel_props.sv ----
// Purpose: Port checks for one output channel
// Assumes: Only top ports seen; byte registers behind a classic Wishbone slave
// Notes: Bound after the module
module ocd_props
  import ocd_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [1:0] OUT_A_P,
  input wire logic [1:0] OUT_A_N,
  input wire logic OUT_A_OE_N,
  input wire logic [1:0] OUT_A_DRIVE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  property p_ack; s_req |=> WB_ACK_O; endproperty
  property p_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
  property p_idle; !WB_ACK_O |-> WB_DAT_O == 32'h0000_0000; endproperty
  property p_rsv; WB_DAT_O[31:8] == 24'h00_0000; endproperty
  property p_off; OUT_A_DRIVE == OCD_DRV_OFF |-> OUT_A_OE_N && (OUT_A_P | OUT_A_N) == 2'h0;
  endproperty
  // Pair must be live and complementary while not powered down
  property p_on; $past(RSTN, 2) && OUT_A_DRIVE != OCD_DRV_OFF |-> !OUT_A_OE_N
    && OUT_A_N == ~OUT_A_P; endproperty
  property p_rst; $rose(RSTN) |-> !WB_ACK_O && OUT_A_P == 2'h0 && OUT_A_DRIVE == 2'h0;
  endproperty
  property p_drv; !$stable(OUT_A_DRIVE) |-> WB_ACK_O || $past(WB_ACK_O); endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  a_idle: assert property (p_idle) else $error("read data without ack");
  a_rsv: assert property (p_rsv) else $error("upper read bits set");
  a_off: assert property (p_off) else $error("powered down pair driven");
  a_on: assert property (p_on) else $error("enabled pair not complementary");
  a_rst: assert property (p_rst) else $error("outputs not at reset values");
  a_drv: assert property (p_drv) else $error("drive changed without write");
endmodule
bind ocd_channel ocd_props u_props (
  .REF_CLK(REF_CLK),
  .RSTN(RSTN),
  .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O),
  .OUT_A_P(OUT_A_P),
  .OUT_A_N(OUT_A_N),
  .OUT_A_OE_N(OUT_A_OE_N),
  .OUT_A_DRIVE(OUT_A_DRIVE)
);

// ---- ocd_rx.sv ----
// Purpose: Receiver model on the differential output pair
// Assumes: One bit per half cycle; P above N reads high
// Notes: A released pair reads as a flipping pattern, never a held level
module ocd_rx
(
  input wire logic clk,
  input wire logic [1:0] p,
  input wire logic [1:0] n,
  input wire logic oe_n,
  output logic [1:0] line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog = 1'b0;
  // Flip each cycle so a stale level cannot pass for a driven one
  always_ff @(posedge clk) tog <= ~tog;
  assign line = oe_n ? {tog, ~tog} : (p & ~n);
endmodule

// ---- test_output_channel_divider_driver.sv ----
// Purpose: Register and divider checks for one output channel
// Assumes: Write stores when taken; outputs show a sync two edges later
// Notes: Pattern checks sample the pair on falling edges
module test_output_channel_divider_driver
  import ocd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, sync = 0, ack, oe_n;
  logic [13:0] adr = 14'h0000;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
  logic [1:0] p, n, drv, line;
  logic [23:0] bits, exp;
  int num_errors = 0, checks_done = 0, cycles = 0, k;
  logic [13:0] ra[5] = '{14'h10DC, 14'h10E0, 14'h10E4, 14'h10E8, 14'h1000};
  logic [7:0] mk[5] = '{8'h07, 8'hFF, 8'h03, 8'h3F, 8'h00};
  always #5 ref_clk = ~ref_clk;
  ocd_channel dut (.REF_CLK(ref_clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .SYNC(sync), .OUT_A_P(p), .OUT_A_N(n), .OUT_A_OE_N(oe_n),
    .OUT_A_DRIVE(drv));
  ocd_rx rx (.clk(ref_clk), .p(p), .n(n), .oe_n(oe_n), .line(line));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // Hold the request until ack is sampled high
  task acc(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {cyc, stb, we, adr, dat_i} <= {2'b11, w, a, 24'h00_0000, d};
    do @(posedge ref_clk); while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask
  task cap;
    for (int i = 0; i < 12; i++) begin
      @(negedge ref_clk);
      bits = {bits[21:0], line};
    end
  endtask
  task run(input int dv, input int ph, input int pl);
    acc(1, 14'h10E0, 8'(dv));
    acc(1, 14'h10E8, 8'(ph));
    acc(1, 14'h10DC, 8'(pl));
    @(posedge ref_clk) sync <= 1;
    @(posedge ref_clk) sync <= 0;
    // Sync is taken one edge after it is driven; the pair shows it one edge later
    repeat (1) @(posedge ref_clk);
    cap();
    for (int i = 0; i < 24; i++) exp[23-i] = pl[0] ^ (i >= ph && (i - ph) % (2 * dv + 2) <= dv);
    chk({8'h00, bits}, {8'h00, exp});
  endtask
  task finish_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1;
    for (k = 0; k < 5; k++) begin
      acc(0, ra[k], 8'h00);
      chk(q, 32'h0000_0000);
    end
    run(0, 0, 0);
    run(2, 1, 1);
    run(2, 7, 0);
    // Held sync would pin a live divider at its start; masked it must run free
    acc(1, 14'h10D8, 8'h01);
    @(posedge ref_clk) sync <= 1;
    repeat (2) @(posedge ref_clk);
    cap();
    chk(32'($countones(bits)), 32'd12);
    @(posedge ref_clk) sync <= 0;
    // Cleared mask must obey sync again
    acc(1, 14'h10D8, 8'h00);
    run(2, 3, 0);
    for (k = 0; k < 4; k++) begin
      acc(1, 14'h10DC, 8'(k * 2));
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(32'(drv), 32'(k));
      chk(32'(oe_n), 32'(k == 3));
    end
    for (k = 0; k < 5; k++) begin
      acc(1, ra[k], 8'hFF);
      acc(0, ra[k], 8'h00);
      chk(q, 32'(mk[k]));
    end
    finish_test();
  end
endmodule
